/* verilog/port_module_10g.sv */
// Configuration, interrupt sources and receive frame checking of the port module
`timescale 1ns/1ps
`include "port_module_10g_cfg.svh"
module port_module_10g (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic resetWrite,
    input wire port_module_10g_pkg::reset_word_t resetWord,
    input wire logic [1:0] speedSel,
    input wire port_module_10g_pkg::port_mode_t portMode,
    input wire logic receivePathOn,
    input wire logic transmitPathOn,
    input wire logic pausePassthrough,
    input wire logic preambleFormat,
    input wire logic gapFormat,
    input wire logic innerHeaderSumCheck,
    input wire logic [13:0] frameLengthLimit,
    input wire logic tagAwareLengthLimit,
    input wire logic [1:0] numTags,
    input wire logic [2:0][15:0] customTagEthertype,
    input wire port_module_10g_pkg::check_cfg_t checkCfg,
    input wire logic [7:0] codingSticky,
    input wire logic [7:0] codingEventMask,
    input wire logic [7:0] fecSticky,
    input wire logic [7:0] fecEventMask,
    input wire logic [7:0] energySticky,
    input wire logic [7:0] energyEventMask,
    input wire logic txLowPower,
    input wire logic rxLowPower,
    input wire logic linkUp,
    input wire port_module_10g_pkg::lane_word_t laneIn,
    input wire logic laneValid,
    output logic laneReady,
    output port_module_10g_pkg::core_word_t coreOut,
    output logic coreValid,
    input wire logic coreReady,
    output port_module_10g_pkg::reset_word_t resetState,
    output port_module_10g_pkg::irq_word_t irqOut,
    output logic baserSelect,
    output logic usxgmiiSelect,
    output logic rate5g,
    output logic speedReserved,
    output logic transmitActive,
    output logic txPreambleStandard,
    output logic txGapNormal,
    output logic pauseFrameSeen,
    output logic frameDropped,
    output logic frameAborted
);
    import port_module_10g_pkg::*;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_FRAME = 2'b01,
        RX_SWALLOW = 2'b10
    } rx_state_t;

    rx_state_t state_r;
    rx_state_t state_nxt;
    logic [13:0] byteCnt_r;
    logic [1:0] tagCnt_r;
    logic typeDone_r;
    logic [7:0] typeHi_r;
    logic [15:0] lenField_r;
    logic rateTick_r;
    logic txLowPower_r;
    logic rxLowPower_r;
    logic linkUp_r;
    irq_word_t irq_r;
    logic [2:0] status_r;
    logic [1:0] speedSel_r;
    port_mode_t portMode_r;

    assign baserSelect = (portMode_r == MODE_BASER_10G) || (portMode_r == MODE_BASER_5G);
    assign usxgmiiSelect = (portMode_r == MODE_DXGMII);

    wire sel5g = (speedSel_r == 2'b01);
    wire sel10g = (speedSel_r == 2'b00);
    assign rate5g = sel5g;
    assign speedReserved = !(sel5g || sel10g);

    assign transmitActive = transmitPathOn && !resetState.macTransmit;
    assign txPreambleStandard = (preambleFormat == 1'b0);
    assign txGapNormal = (gapFormat == 1'b0);

    // Config latched so a change only lands through the reset cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            speedSel_r <= 2'b00;
            portMode_r <= MODE_BASER_10G;
        end else if (resetState.macReceive && resetState.macTransmit) begin
            speedSel_r <= speedSel;
            portMode_r <= portMode;
        end
    end

    port_reset_ctrl resetCtrl (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .resetWrite(resetWrite),
        .resetWord(resetWord),
        .resetState(resetState)
    );

    // full rate at 10G, no shrink
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rateTick_r <= 1'b0;
        end else begin
            rateTick_r <= sel5g ? !rateTick_r : 1'b1;
        end
    end

    wire codingAny = |(codingSticky & codingEventMask);
    wire fecAny = |(fecSticky & fecEventMask);
    wire energyAny = |(energySticky & energyEventMask);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            // Pins tracked in reset, else release shows a false change
            txLowPower_r <= txLowPower;
            rxLowPower_r <= rxLowPower;
            linkUp_r <= linkUp;
            irq_r <= '0;
        end else begin
            txLowPower_r <= txLowPower;
            rxLowPower_r <= rxLowPower;
            linkUp_r <= linkUp;
            irq_r.baserCoding <= baserSelect && (codingAny || fecAny || energyAny);
            irq_r.txLowPowerChange <= txLowPower ^ txLowPower_r;
            irq_r.rxLowPowerChange <= rxLowPower ^ rxLowPower_r;
            irq_r.linkRise <= linkUp && !linkUp_r;
            irq_r.linkFall <= !linkUp && linkUp_r;
        end
    end
    assign irqOut = irq_r;

    // Receive frame checking
    wire rxRun = receivePathOn && !resetState.macReceive && !resetState.codingReceive;
    wire bufReady;
    wire laneTake = laneValid && laneReady;
    assign laneReady = rxRun && rateTick_r && ((state_r == RX_SWALLOW) || bufReady);

    wire [14:0] limitBase = ({1'b0, frameLengthLimit} > `FRAME_LEN_CEIL) ? `FRAME_LEN_CEIL
                                                                          : {1'b0, frameLengthLimit};
    wire [14:0] tagExtra = tagAwareLengthLimit ? (`TAG_BYTES * 15'(tagCnt_r)) : 15'h0000;
    wire [14:0] effLimit = limitBase + tagExtra;

    wire [13:0] curCnt = (state_r == RX_FRAME) ? byteCnt_r : 14'h0000;
    wire [13:0] typePos = `ETHERTYPE_POS + {10'h000, tagCnt_r, 2'b00};
    wire [15:0] typeNow = {typeHi_r, laneIn.data};
    wire atTypeHi = !typeDone_r && (curCnt == typePos);
    wire atTypeLo = !typeDone_r && (curCnt == typePos + 14'h0001);

    wire isTag = (typeNow == `VLAN_ETHERTYPE) || (typeNow == customTagEthertype[0])
        || (typeNow == customTagEthertype[1]) || (typeNow == customTagEthertype[2]);
    wire tagStep = atTypeLo && isTag && (tagCnt_r < numTags);
    wire [15:0] lenFinal = (atTypeLo && !tagStep) ? typeNow : lenField_r;

    wire hitLimit = ({1'b0, curCnt} + 15'h0001 >= effLimit) && !laneIn.eop;
    wire frameEnd = laneIn.eop || hitLimit;

    wire [13:0] overhead = `HEADER_BYTES + `FCS_BYTES + {10'h000, tagCnt_r, 2'b00};
    wire [13:0] frameBytes = curCnt + 14'h0001;
    wire [15:0] payloadLen = (frameBytes > overhead) ? {2'b00, frameBytes - overhead} : 16'h0000;
    wire isLength = lenFinal < `TYPE_FLOOR;
    wire lenMatch = (payloadLen == lenFinal) || ((payloadLen == `PAYLOAD_PAD_MIN) && (lenFinal < `PAYLOAD_PAD_MIN));
    wire inrangeErr = isLength && (lenFinal <= `PAYLOAD_CEIL) && !lenMatch;
    wire outrangeErr = isLength && (lenFinal > `PAYLOAD_CEIL);

    wire lenDrop = (inrangeErr && checkCfg.inrangeLenDropOn) || (outrangeErr && checkCfg.outrangeLenDropOn);

    wire advDrop = (checkCfg.endPacketCheckOn && laneIn.endPacketBad)
        || (checkCfg.startPacketCheckOn && laneIn.startPacketBad)
        || (checkCfg.delimiterCheckOn && laneIn.delimiterBad)
        || (checkCfg.preambleCheckOn && laneIn.preambleBad)
        || (!checkCfg.preambleShrinkCheckOff && laneIn.preambleShrunk);

    wire sumDrop = innerHeaderSumCheck && laneIn.innerSumBad;

    wire isPause = (lenFinal == `PAUSE_ETHERTYPE);
    wire pauseDrop = isPause && !pausePassthrough;

    wire endDrop = lenDrop || advDrop || sumDrop || pauseDrop;

    core_word_t pushWord;
    always_comb begin
        pushWord = '0;
        pushWord.data = laneIn.data;
        pushWord.sop = laneIn.sop;
        pushWord.eop = frameEnd;
        pushWord.aborted = hitLimit;
        pushWord.discard = frameEnd && endDrop;
    end

    wire startOk = laneIn.sop;
    wire pushValid = laneValid && laneReady && (state_r != RX_SWALLOW)
        && ((state_r == RX_FRAME) || startOk);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RX_IDLE: begin
                if (laneTake && startOk && !frameEnd) begin
                    state_nxt = RX_FRAME;
                end else if (laneTake && startOk && hitLimit) begin
                    state_nxt = RX_SWALLOW;
                end
            end
            RX_FRAME: begin
                if (laneTake && hitLimit) begin
                    state_nxt = RX_SWALLOW;
                end else if (laneTake && laneIn.eop) begin
                    state_nxt = RX_IDLE;
                end
            end
            RX_SWALLOW: begin
                // Rest of an overlong frame thrown away until its end
                if (laneTake && laneIn.eop) begin
                    state_nxt = RX_IDLE;
                end
            end
            default: begin
                state_nxt = RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || !rxRun) begin
            state_r <= RX_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Header tracking; a new start clears the counts and type flag and keeps the held type bytes, unless the frame also ends in that first word
    always_ff @(posedge ref_clk) begin
        if (!rst_n || (pushValid && laneIn.sop && state_r == RX_IDLE && frameEnd)) begin
            byteCnt_r <= 14'h0000;
            tagCnt_r <= 2'b00;
            typeDone_r <= 1'b0;
            typeHi_r <= 8'h00;
            lenField_r <= 16'h0000;
        end else if (pushValid) begin
            byteCnt_r <= curCnt + 14'h0001;
            if (state_r == RX_IDLE) begin
                tagCnt_r <= 2'b00;
                typeDone_r <= 1'b0;
            end
            if (atTypeHi) begin
                typeHi_r <= laneIn.data;
            end
            if (tagStep) begin
                tagCnt_r <= tagCnt_r + 2'b01;
            end else if (atTypeLo) begin
                typeDone_r <= 1'b1;
                lenField_r <= typeNow;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            status_r <= 3'b000;
        end else begin
            status_r[0] <= pushValid && frameEnd && isPause;
            status_r[1] <= pushValid && frameEnd && endDrop;
            status_r[2] <= pushValid && hitLimit;
        end
    end
    assign pauseFrameSeen = status_r[0];
    assign frameDropped = status_r[1];
    assign frameAborted = status_r[2];

    // Stall at the core backs up into the lane through laneReady
    port_rx_buffer #(
        .WIDTH($bits(core_word_t)),
        .DEPTH(2)
    ) rxBuffer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inValid(pushValid),
        .inReady(bufReady),
        .inData(pushWord),
        .outValid(coreValid),
        .outReady(coreReady),
        .outData(coreOut)
    );
endmodule : port_module_10g

/* verilog/port_module_10g_cfg.svh */
// Constants of the 10G/5G port module receive checker
`ifndef PORT_MODULE_10G_CFG_SVH
`define PORT_MODULE_10G_CFG_SVH
`define FRAME_LEN_CEIL 15'h36b0
`define VLAN_ETHERTYPE 16'h8100
`define PAUSE_ETHERTYPE 16'h8808
`define TYPE_FLOOR 16'h0600
`define PAYLOAD_CEIL 16'h05dc
`define PAYLOAD_PAD_MIN 16'h002e
`define HEADER_BYTES 14'h000e
`define FCS_BYTES 14'h0004
`define TAG_BYTES 15'h0004
`define ETHERTYPE_POS 14'h000c
`define RESET_ALL 4'hf
`endif

/* verilog/port_module_10g_pkg.sv */
// Types shared by the port module receive checker
package port_module_10g_pkg;
    typedef enum logic [1:0] {
        MODE_BASER_10G = 2'b00,
        MODE_BASER_5G = 2'b01,
        MODE_DXGMII = 2'b10,
        MODE_RSVD = 2'b11
    } port_mode_t;

    typedef struct packed {
        logic macReceive;
        logic macTransmit;
        logic codingReceive;
        logic codingTransmit;
    } reset_word_t;

    typedef struct packed {
        logic endPacketCheckOn;
        logic startPacketCheckOn;
        logic delimiterCheckOn;
        logic preambleShrinkCheckOff;
        logic preambleCheckOn;
        logic inrangeLenDropOn;
        logic outrangeLenDropOn;
    } check_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic sop;
        logic eop;
        logic endPacketBad;
        logic startPacketBad;
        logic delimiterBad;
        logic preambleBad;
        logic preambleShrunk;
        logic innerSumBad;
    } lane_word_t;

    typedef struct packed {
        logic [7:0] data;
        logic sop;
        logic eop;
        logic aborted;
        logic discard;
    } core_word_t;

    typedef struct packed {
        logic baserCoding;
        logic txLowPowerChange;
        logic rxLowPowerChange;
        logic linkRise;
        logic linkFall;
    } irq_word_t;
endpackage : port_module_10g_pkg

/* verilog/port_reset_ctrl.sv */
// Four per-direction synchronous resets of the port module
`timescale 1ns/1ps
`include "port_module_10g_cfg.svh"
module port_reset_ctrl (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic resetWrite,
    input wire port_module_10g_pkg::reset_word_t resetWord,
    output port_module_10g_pkg::reset_word_t resetState
);
    import port_module_10g_pkg::*;

    reset_word_t resetState_r;

    assign resetState = resetState_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            resetState_r <= reset_word_t'(`RESET_ALL);
        end else if (resetWrite) begin
            resetState_r <= resetWord;
        end
    end
endmodule : port_reset_ctrl

/* verilog/port_rx_buffer.sv */
// Two-entry buffer between receive checker and switch core
`timescale 1ns/1ps
module port_rx_buffer #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    wire doPush = inValid && inReady;
    wire doPop = outValid && outReady;

    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = store_r[rdPtr_r];

    always_ff @(posedge ref_clk) begin
        if (doPush) begin
            store_r[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doPush) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (doPop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule : port_rx_buffer

/* testbench/port_module_10g_chk.sv */
// Port-level assertions for the port module
`timescale 1ns/1ps
module port_module_10g_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic resetWrite,
    input wire port_module_10g_pkg::reset_word_t resetWord,
    input wire logic receivePathOn,
    input wire logic transmitPathOn,
    input wire logic preambleFormat,
    input wire logic gapFormat,
    input wire logic [7:0] codingSticky,
    input wire logic [7:0] codingEventMask,
    input wire logic [7:0] fecSticky,
    input wire logic [7:0] fecEventMask,
    input wire logic [7:0] energySticky,
    input wire logic [7:0] energyEventMask,
    input wire logic linkUp,
    input wire logic laneReady,
    input wire port_module_10g_pkg::core_word_t coreOut,
    input wire logic coreValid,
    input wire logic coreReady,
    input wire port_module_10g_pkg::reset_word_t resetState,
    input wire port_module_10g_pkg::irq_word_t irqOut,
    input wire logic baserSelect,
    input wire logic usxgmiiSelect,
    input wire logic rate5g,
    input wire logic transmitActive,
    input wire logic txPreambleStandard,
    input wire logic txGapNormal,
    input wire logic frameAborted,
    input wire logic frameDropped
);
    import port_module_10g_pkg::*;
    wire logic evSel = baserSelect & (|(codingSticky & codingEventMask) | |(fecSticky & fecEventMask)
        | |(energySticky & energyEventMask));
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    rst_load_a: assert property (resetWrite |=> resetState == $past(resetWord))
        else $error("reset state not loaded");
    rst_hold_a: assert property (!resetWrite |=> $stable(resetState))
        else $error("reset state moved without write");
    tx_active_a: assert property (transmitActive == (transmitPathOn && !resetState.macTransmit))
        else $error("transmit enable wrong");
    rx_gate_a: assert property ((!receivePathOn || resetState.macReceive) |-> !laneReady)
        else $error("lane accepted while receive off");
    format_out_a: assert property (txPreambleStandard == !preambleFormat && txGapNormal == !gapFormat)
        else $error("format outputs wrong");
    half_rate_a: assert property (rate5g && laneReady |=> !laneReady)
        else $error("lane taken twice in a row at 5G");
    mode_excl_a: assert property (!(baserSelect && usxgmiiSelect))
        else $error("two coding layers selected");
    masked_irq_a: assert property (1'b1 |=> irqOut.baserCoding == $past(evSel))
        else $error("coding interrupt ignores masks");
    link_rise_a: assert property ($rose(linkUp) |=> irqOut.linkRise && !irqOut.linkFall)
        else $error("link rise not flagged");
    link_fall_a: assert property ($fell(linkUp) |=> irqOut.linkFall ##1 !irqOut.linkFall)
        else $error("link fall not a single pulse");
    core_hold_a: assert property (coreValid && !coreReady |=> coreValid && $stable(coreOut))
        else $error("core word lost during stall");
    rise_cov: cover property (irqOut.linkRise);
    abort_cov: cover property (frameAborted);
    drop_cov: cover property (frameDropped);
    stall_cov: cover property (coreValid && !coreReady);
endmodule : port_module_10g_chk
bind port_module_10g port_module_10g_chk chk (.*);

/* testbench/port_core_sink.sv */
// Switch core sink that can stall the receive path
`timescale 1ns/1ps
module port_core_sink (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic stallOn,
    input wire logic coreValid,
    output logic coreReady,
    output logic took
);
    logic [1:0] cnt_r;
    always_ff @(posedge ref_clk) begin
        cnt_r <= rst_n ? cnt_r + 2'h1 : 2'h0;
    end
    // One cycle in four while stalling, so the two-entry buffer fills
    assign coreReady = !stallOn || (cnt_r == 2'h3);
    assign took = coreValid && coreReady;
endmodule : port_core_sink

/* testbench/tb_port_module_10g.sv */
// Self-checking bench of the port module
`timescale 1ns/1ps
module tb_port_module_10g;
    import port_module_10g_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, resetWrite = 1'b0, receivePathOn = 1'b1, transmitPathOn = 1'b1;
    logic pausePassthrough = 1'b0, preambleFormat = 1'b0, gapFormat = 1'b0, innerHeaderSumCheck = 1'b0;
    logic tagAwareLengthLimit = 1'b0, txLowPower = 1'b0, rxLowPower = 1'b0, linkUp = 1'b0;
    logic laneValid = 1'b0, stallOn = 1'b0;
    logic [1:0] speedSel = 2'h0, numTags = 2'h0;
    logic [13:0] frameLengthLimit = 14'h05f2;
    logic [2:0][15:0] customTagEthertype = {16'h9200, 16'h9100, 16'h88a8};
    logic [7:0] codingSticky = 8'h0, codingEventMask = 8'h0, fecSticky = 8'h0;
    logic [7:0] fecEventMask = 8'h0, energySticky = 8'h0, energyEventMask = 8'h0;
    reset_word_t resetWord = 4'h0, resetState;
    port_mode_t portMode = MODE_BASER_10G;
    check_cfg_t checkCfg = 7'h08;
    lane_word_t laneIn = '0;
    core_word_t coreOut;
    irq_word_t irqOut;
    logic laneReady, coreValid, coreReady, took, baserSelect, usxgmiiSelect, rate5g, speedReserved;
    logic transmitActive, txPreambleStandard, txGapNormal, pauseFrameSeen, frameDropped, frameAborted;
    int seed = 34, err_total = 0, compares = 0, nDrop = 0, nAbort = 0, nPause = 0, xDrop = 0, xAbort = 0, xPause = 0;
    logic [11:0] expq[$];
    logic [15:0] lenType[6] = '{16'h002e, 16'h0020, 16'h0030, 16'h05dd, 16'h05ff, 16'h0600};
    port_module_10g dut (.*);
    port_core_sink sink (.*);
    initial begin
        forever #50 ref_clk = !ref_clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    // Sampled mid-cycle, so a word seen here is taken at the coming edge
    always @(negedge ref_clk) begin
        if (took === 1'b1) check("core word", coreOut, expq.pop_front());
        nDrop += (frameDropped === 1'b1);
        nAbort += (frameAborted === 1'b1);
        nPause += (pauseFrameSeen === 1'b1);
    end
    task automatic rcycle;
        @(negedge ref_clk);
        resetWrite = 1'b1;
        resetWord = 4'hf;
        @(negedge ref_clk);
        resetWord = 4'h0;
        @(negedge ref_clk);
        resetWrite = 1'b0;
        @(negedge ref_clk);
        check("reset clear", resetState, 4'h0);
    endtask : rcycle
    task automatic send(input int n, input logic [15:0] et, input logic [5:0] fl, input int tags,
        input logic [15:0] tt);
        int lim, ct, pay, m;
        logic ab, disc, adv;
        logic [7:0] b;
        ct = (tags < numTags) ? tags : numTags;
        lim = (frameLengthLimit > 14000 ? 14000 : frameLengthLimit) + (tagAwareLengthLimit ? 4 * ct : 0);
        pay = n - 18 - 4 * ct;
        ab = n > lim;
        adv = |(fl[5:1] & {checkCfg.endPacketCheckOn, checkCfg.startPacketCheckOn, checkCfg.delimiterCheckOn,
            checkCfg.preambleCheckOn, !checkCfg.preambleShrinkCheckOff}) || (innerHeaderSumCheck && fl[0]);
        disc = !ab && (adv || (checkCfg.inrangeLenDropOn && et <= 1500 && et != pay && !(et < 46 && pay == 46))
            || (checkCfg.outrangeLenDropOn && et > 1500 && et < 1536) || (!pausePassthrough && et == 16'h8808));
        xDrop += disc;
        xAbort += ab;
        xPause += (et == 16'h8808);
        m = ab ? lim : n;
        for (int i = 0; i < n; i++) begin
            if (i < 12 || i >= 14 + 4 * tags) b = 8'($random(seed));
            else if (i >= 12 + 4 * tags) b = (i % 2) ? et[7:0] : et[15:8];
            else b = (i % 4 == 0) ? tt[15:8] : (i % 4 == 1) ? tt[7:0] : 8'($random(seed));
            if (i < m) expq.push_back({b, i == 0, i == m - 1, ab && i == m - 1, disc && i == m - 1});
            laneIn = {b, i == 0, i == n - 1, (i == n - 1) ? fl : 6'h0};
            laneValid = 1'b1;
            while (laneReady !== 1'b1) @(negedge ref_clk);
            @(negedge ref_clk);
        end
        laneValid = 1'b0;
        @(negedge ref_clk);
    endtask : send
    task automatic endt(input string name);
        for (int k = 0; k < 400 && expq.size() != 0; k++) @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
        check("queue left", 16'(expq.size()), 16'h0);
        check("drops", 16'(nDrop), 16'(xDrop));
        check("aborts", 16'(nAbort), 16'(xAbort));
        check("pauses", 16'(nPause), 16'(xPause));
        $display("test %s done", name);
    endtask : endt
    task automatic irq_chk(input int k, input logic [4:0] exp);
        if (k == 0) linkUp = !linkUp;
        else if (k == 1) txLowPower = !txLowPower;
        else rxLowPower = !rxLowPower;
        @(negedge ref_clk);
        check("irq pulse", irqOut, exp);
        @(negedge ref_clk);
        check("irq quiet", irqOut, 5'h0);
    endtask : irq_chk
    initial begin
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        check("reset hold", resetState, 4'hf);
        check("rx blocked", laneReady, 1'b0);
        rcycle();
        stallOn = 1'b1;
        send(64, 16'h0800, 6'h0, 0, 16'h8100);
        send(60, 16'h0800, 6'h0, 0, 16'h8100);
        endt("stall");
        stallOn = 1'b0;
        checkCfg = 7'h0b;
        foreach (lenType[i]) send(64, lenType[i], 6'h0, 0, 16'h8100);
        endt("length");
        checkCfg = 7'h08;
        send(64, 16'h8808, 6'h0, 0, 16'h8100);
        pausePassthrough = 1'b1;
        send(64, 16'h8808, 6'h0, 0, 16'h8100);
        endt("pause");
        checkCfg = 7'h74;
        innerHeaderSumCheck = 1'b1;
        for (int k = 0; k < 6; k++) send(64, 16'h0800, 6'h01 << k, 0, 16'h8100);
        checkCfg = 7'h08;
        innerHeaderSumCheck = 1'b0;
        for (int k = 0; k < 6; k++) send(64, 16'h0800, 6'h01 << k, 0, 16'h8100);
        endt("checks");
        frameLengthLimit = 14'h0040;
        send(80, 16'h0800, 6'h0, 0, 16'h8100);
        tagAwareLengthLimit = 1'b1;
        numTags = 2'h1;
        send(70, 16'h0800, 6'h0, 1, 16'h8100);
        numTags = 2'h3;
        send(76, 16'h0800, 6'h0, 3, 16'h88a8);
        send(77, 16'h0800, 6'h0, 3, 16'h9100);
        endt("tags");
        frameLengthLimit = 14'h05f2;
        portMode = MODE_BASER_5G;
        speedSel = 2'h1;
        rcycle();
        check("5g mode", {baserSelect, rate5g}, 2'h3);
        send(64, 16'h0800, 6'h0, 0, 16'h8100);
        endt("half rate");
        speedSel = 2'h2;
        rcycle();
        check("reserved", speedReserved, 1'b1);
        portMode = MODE_DXGMII;
        speedSel = 2'h0;
        rcycle();
        check("dxgmii", {usxgmiiSelect, baserSelect, rate5g}, 3'h4);
        portMode = MODE_BASER_10G;
        rcycle();
        check("10g mode", {usxgmiiSelect, baserSelect, rate5g, speedReserved}, 4'h4);
        receivePathOn = 1'b0;
        transmitPathOn = 1'b0;
        preambleFormat = 1'b1;
        @(negedge ref_clk);
        check("rx off", {laneReady, transmitActive}, 2'h0);
        check("formats", {txPreambleStandard, txGapNormal}, 2'h1);
        receivePathOn = 1'b1;
        transmitPathOn = 1'b1;
        @(negedge ref_clk);
        check("tx on", transmitActive, 1'b1);
        irq_chk(0, 5'h02);
        irq_chk(0, 5'h01);
        irq_chk(1, 5'h08);
        irq_chk(2, 5'h04);
        for (int s = 0; s < 6; s++) begin
            {codingSticky, fecSticky, energySticky} = (24'h100000 >> (8 * (s / 2)));
            {codingEventMask, fecEventMask, energyEventMask} = (s % 2) ? 24'h101010 : 24'hefefef;
            repeat (2) @(negedge ref_clk);
            check("masked irq", irqOut.baserCoding, 16'(s % 2));
        end
        {codingSticky, fecSticky, energySticky} = 24'h0;
        $display("test irq done");
        rst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        check("mid reset", {resetState, irqOut}, 9'h1e0);
        {nDrop, nAbort, nPause, xDrop, xAbort, xPause} = '0;
        rcycle();
        send(64, 16'h0800, 6'h0, 0, 16'h8100);
        endt("mid reset");
        tally_and_finish();
    end
    // Whole sequence needs a few thousand cycles; allow ample margin
    initial begin
        #(30000 * 100);
        err_total++;
        tally_and_finish();
    end
endmodule : tb_port_module_10g
